// ===== design/dci_defs.vh
// Constants for the digital command input front end.
`ifndef DCI_DEFS_VH
`define DCI_DEFS_VH

// Register indexes, kept exactly as the object indexes.
`define DCI_IDX_CFG 16'h2320
`define DCI_IDX_SCALE 16'h2321
`define DCI_IDX_DIN 16'h60fd

// Reset values and the mask of writable configuration bits.
`define DCI_CFG_RST 16'h0000
`define DCI_SCALE_RST 32'h00000000
`define DCI_CFG_MASK 16'hf30f

// Configuration bit positions.
`define DCI_B_SIGNMAG 0
`define DCI_B_PWM_INV 1
`define DCI_B_SIGN_INV 2
`define DCI_B_ALLOW_FULL 3
`define DCI_F_FMT_LO 8
`define DCI_F_FMT_HI 9
`define DCI_B_FALL 12
`define DCI_B_DIR_INV 13
`define DCI_F_SRC_LO 14
`define DCI_F_SRC_HI 15

// Position input formats.
`define DCI_FMT_STEPDIR 2'h0
`define DCI_FMT_UPDOWN 2'h1
`define DCI_FMT_QUAD 2'h2

// Operating modes seen on the mode input.
`define DCI_MODE_CUR 2'h1
`define DCI_MODE_VEL 2'h2
`define DCI_MODE_POS 2'h3

// Divider geometry and default PWM timeout in clock cycles.
`define DCI_DIV_W 48
`define DCI_DIV_STEPS 6'h30
`define DCI_PWM_TMO 65535

`endif

// ===== design/dci_div.v
// Sequential restoring divider shared by PWM scaling and position ratio.
module dci_div (
  // Clock, reset and enable.
  input wire clk_in,
  input wire rst_b_in,
  input wire ce_in,
  // Request.
  input wire start_in,
  input wire [47:0] dividend_in,
  input wire [15:0] divisor_in,
  // Result.
  output wire busy_out,
  output reg done_out,
  output wire [47:0] quotient_out,
  output wire [15:0] remainder_out
);
`include "dci_defs.vh"

  reg [47:0] quo_r; // Dividend shifts out, quotient shifts in.
  reg [15:0] rem_r; // Partial remainder.
  reg [15:0] dvs_r; // Latched divisor.
  reg [5:0] cnt_r; // Steps left.
  reg busy_r; // Division running.
  wire [16:0] shf; // Remainder with the next dividend bit.
  wire [16:0] dif; // Trial subtraction.
  wire ge; // Divisor fits into the partial remainder.

  assign shf = {rem_r, quo_r[47]};
  assign dif = shf - {1'b0, dvs_r};
  assign ge = (shf >= {1'b0, dvs_r});
  assign busy_out = busy_r;
  assign quotient_out = quo_r;
  assign remainder_out = rem_r;

  // One quotient bit per cycle; a zero divisor must be refused upstream.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      quo_r <= 48'h0;
      rem_r <= 16'h0;
      dvs_r <= 16'h0;
      cnt_r <= 6'h0;
      busy_r <= 1'b0;
      done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      if (start_in && !busy_r)
      begin
        quo_r <= dividend_in;
        rem_r <= 16'h0;
        dvs_r <= divisor_in;
        cnt_r <= `DCI_DIV_STEPS;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        quo_r <= {quo_r[46:0], ge};
        rem_r <= ge ? dif[15:0] : shf[15:0];
        cnt_r <= cnt_r - 6'h1;
        if (cnt_r == 6'h1)
        begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // dci_div

// ===== design/dci_front_end.v
// Digital command input front end: PWM and pulse decoding, input status.
`include "dci_defs.vh"

module dci_front_end #(
  parameter [15:0] PWM_TMO = `DCI_PWM_TMO
) (
  // Clock, reset and enable.
  input wire clk_in,
  input wire rst_b_in,
  input wire ce_in,
  // Register port, indexed by object index.
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_idx_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_ack_out,
  // Drive state from the rest of the drive.
  input wire dig_src_in,
  input wire [1:0] op_mode_in,
  // Command pins from the motion controller.
  input wire pwm_in,
  input wire sign_in,
  input wire [3:0] src_a_in,
  input wire [3:0] src_b_in,
  // Input function and raw pin levels.
  input wire neg_lim_in,
  input wire pos_lim_in,
  input wire home_in,
  input wire drv_en_in,
  input wire [15:0] raw_pins_in,
  // Motion commands.
  output reg [31:0] cmd_out,
  output reg cmd_valid_out,
  output reg [31:0] pos_cmd_out
);

  // States of the divider owner, one-hot.
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PWM = 3'h2;
  localparam [2:0] ST_POS = 3'h4;

  reg rst_s1_r; // Reset release, first stage.
  reg rst_n_r; // Released reset used by the whole block.
  reg [29:0] meta_r; // Pin synchroniser, first stage.
  reg [29:0] sync_r; // Pin synchroniser, second stage.
  reg [15:0] cfg_r; // Command input configuration.
  reg [31:0] scale_r; // Command input scaling.
  reg [2:0] st_r; // Divider owner state.
  reg [2:0] st_nxt; // Next divider owner state.
  reg pwm_d_r; // Previous sensed PWM level.
  reg [15:0] hi_cnt_r; // High cycles in this period.
  reg [15:0] per_cnt_r; // Cycles since the last rising edge.
  reg [15:0] hi_cap_r; // Captured high time.
  reg [15:0] per_cap_r; // Captured period.
  reg full_r; // Capture came from a stuck-high input.
  reg tmo_r; // Timeout already reported for this gap.
  reg meas_r; // A capture waits to be scaled.
  reg neg_r; // Sign of the result in flight.
  reg a_d_r; // Previous selected A input.
  reg b_d_r; // Previous selected B input.
  reg [15:0] pend_r; // Signed count of steps not yet applied.
  reg [15:0] pend_nxt; // Next pending count.
  reg [16:0] rem_r; // Signed fractional remainder.
  reg net_up; // One step forward this cycle.
  reg net_dn; // One step backward this cycle.
  reg [47:0] dvd; // Divider dividend.
  reg [15:0] dvs; // Divider divisor.

  wire pwm_s; // Sensed PWM after optional inversion.
  wire sign_s; // Synchronised sign pin.
  wire [3:0] a_s; // Synchronised A inputs.
  wire [3:0] b_s; // Synchronised B inputs.
  wire [3:0] fn_s; // Synchronised limit, home and enable.
  wire [15:0] raw_s; // Synchronised raw pins.
  wire active; // Drive runs from the digital command inputs.
  wire pwm_act; // Current or velocity mode from PWM.
  wire pos_act; // Position mode from pulses.
  wire [1:0] fmt; // Position input format.
  wire [1:0] src; // Position input source.
  wire a_in; // Selected A input.
  wire b_in; // Selected B input.
  wire edge_a; // Counted edge on A.
  wire edge_b; // Counted edge on B.
  wire [15:0] num; // Ratio numerator.
  wire [15:0] den; // Ratio denominator.
  wire [31:0] abs_sc; // Magnitude of the PWM scale.
  wire [16:0] off_d; // Twice high time minus period.
  wire [15:0] pwm_mag; // Duty term before scaling.
  wire pwm_neg; // PWM command sign before the scale sign.
  wire [17:0] pos_t; // Remainder plus or minus one numerator.
  wire [17:0] abs_t; // Magnitude of pos_t.
  wire take_pwm; // Start scaling a capture.
  wire zero_pwm; // Capture resolves to zero without dividing.
  wire take_pos; // Start applying one pending step.
  wire div_done; // Divider finished.
  wire [47:0] quo; // Divider quotient.
  wire [15:0] rmd; // Divider remainder.
  wire [31:0] din_word; // Digital inputs status word.

  // Reset is applied at once and released through two flip-flops.
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Every pin is asynchronous to clk_in, so all pass two flip-flops.
  always @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      meta_r <= 30'h0;
      sync_r <= 30'h0;
    end
    else if (ce_in)
    begin
      meta_r <= {raw_pins_in, drv_en_in, home_in, pos_lim_in, neg_lim_in,
                 src_b_in, src_a_in, sign_in, pwm_in};
      sync_r <= meta_r;
    end
  end

  assign pwm_s = sync_r[0] ^ cfg_r[`DCI_B_PWM_INV];
  assign sign_s = sync_r[1];
  assign a_s = sync_r[5:2];
  assign b_s = sync_r[9:6];
  assign fn_s = sync_r[13:10];
  assign raw_s = sync_r[29:14];

  // Configuration is honoured only in modes fed by these inputs.
  assign active = dig_src_in && (op_mode_in != 2'h0);
  assign pwm_act = active && ((op_mode_in == `DCI_MODE_CUR) ||
                              (op_mode_in == `DCI_MODE_VEL));
  assign pos_act = active && (op_mode_in == `DCI_MODE_POS);
  assign fmt = cfg_r[`DCI_F_FMT_HI:`DCI_F_FMT_LO];
  assign src = cfg_r[`DCI_F_SRC_HI:`DCI_F_SRC_LO];
  assign num = scale_r[15:0];
  assign den = scale_r[31:16];

  // Status word: functions low, raw pins high, reserved bits zero.
  assign din_word = {raw_s, 12'h000, fn_s};

  // Register access; the reply and acknowledge follow one cycle later.
  always @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cfg_r <= `DCI_CFG_RST;
      scale_r <= `DCI_SCALE_RST;
      reg_rdata_out <= 32'h0;
      reg_ack_out <= 1'b0;
    end
    else if (ce_in)
    begin
      reg_ack_out <= reg_wr_in | reg_rd_in;
      if (reg_wr_in && (reg_idx_in == `DCI_IDX_CFG))
      begin
        cfg_r <= reg_wdata_in[15:0] & `DCI_CFG_MASK;
      end
      if (reg_wr_in && (reg_idx_in == `DCI_IDX_SCALE))
      begin
        scale_r <= reg_wdata_in;
      end
      if (reg_rd_in)
      begin
        case (reg_idx_in)
          `DCI_IDX_CFG: reg_rdata_out <= {16'h0000, cfg_r};
          `DCI_IDX_SCALE: reg_rdata_out <= scale_r;
          `DCI_IDX_DIN: reg_rdata_out <= din_word;
          default: reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

  // PWM timing. A gap of PWM_TMO cycles without a rising edge means the
  // input is stuck; a stuck-high input is the 100% duty case.
  always @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pwm_d_r <= 1'b0;
      hi_cnt_r <= 16'h0;
      per_cnt_r <= 16'h0;
      hi_cap_r <= 16'h0;
      per_cap_r <= 16'h0;
      full_r <= 1'b0;
      tmo_r <= 1'b0;
      meas_r <= 1'b0;
    end
    else if (ce_in)
    begin
      pwm_d_r <= pwm_s;
      if (take_pwm || zero_pwm || !pwm_act)
      begin
        meas_r <= 1'b0;
      end
      if (pwm_s && !pwm_d_r)
      begin
        hi_cap_r <= hi_cnt_r;
        per_cap_r <= per_cnt_r;
        // An edge after a gap that stayed high throughout is still full
        // duty, so a stuck-high input cannot slip through as a command.
        full_r <= (hi_cnt_r == per_cnt_r);
        tmo_r <= 1'b0;
        meas_r <= pwm_act;
        hi_cnt_r <= 16'h1;
        per_cnt_r <= 16'h1;
      end
      else
      begin
        if (per_cnt_r != PWM_TMO)
        begin
          per_cnt_r <= per_cnt_r + 16'h1;
        end
        if (pwm_s && (hi_cnt_r != PWM_TMO))
        begin
          hi_cnt_r <= hi_cnt_r + 16'h1;
        end
        if ((per_cnt_r == PWM_TMO) && !tmo_r)
        begin
          hi_cap_r <= pwm_s ? PWM_TMO : 16'h0;
          per_cap_r <= PWM_TMO;
          full_r <= pwm_s;
          tmo_r <= 1'b1;
          meas_r <= pwm_act;
        end
      end
    end
  end

  // Duty term: signed/magnitude uses the high time and the sign pin,
  // offset mode uses twice the distance of the high time from half a period.
  assign off_d = {hi_cap_r, 1'b0} - {1'b0, per_cap_r};
  assign pwm_mag = cfg_r[`DCI_B_SIGNMAG] ? hi_cap_r :
                   (off_d[16] ? 16'h0 - off_d[15:0] : off_d[15:0]);
  assign pwm_neg = cfg_r[`DCI_B_SIGNMAG] ?
                   (sign_s ^ cfg_r[`DCI_B_SIGN_INV]) : off_d[16];
  assign abs_sc = scale_r[31] ? 32'h0 - scale_r : scale_r;

  // A stuck-high input gives zero unless full duty is allowed.
  assign zero_pwm = (st_r == ST_IDLE) && meas_r && pwm_act &&
                    ((full_r && !cfg_r[`DCI_B_ALLOW_FULL]) ||
                     (per_cap_r == 16'h0));
  assign take_pwm = (st_r == ST_IDLE) && meas_r && pwm_act && !zero_pwm;

  // Pulse source and edge selection.
  assign a_in = a_s[src];
  assign b_in = b_s[src];
  assign edge_a = cfg_r[`DCI_B_FALL] ? (a_d_r && !a_in) :
                  (a_in && !a_d_r);
  assign edge_b = cfg_r[`DCI_B_FALL] ? (b_d_r && !b_in) :
                  (b_in && !b_d_r);

  // Decode one forward or backward count per cycle from the format.
  always @*
  begin
    net_up = 1'b0;
    net_dn = 1'b0;
    case (fmt)
      `DCI_FMT_STEPDIR:
      begin
        // Direction level is taken as it stands at the step edge.
        net_up = edge_a && !b_in;
        net_dn = edge_a && b_in;
      end
      `DCI_FMT_UPDOWN:
      begin
        net_up = edge_a && !edge_b;
        net_dn = edge_b && !edge_a;
      end
      `DCI_FMT_QUAD:
      begin
        // Every single transition counts; a double jump is dropped.
        if ((a_in ^ a_d_r) ^ (b_in ^ b_d_r))
        begin
          net_up = a_in ^ b_d_r;
          net_dn = !(a_in ^ b_d_r);
        end
      end
      default:
      begin
        net_up = 1'b0;
        net_dn = 1'b0;
      end
    endcase
    if (!pos_act)
    begin
      net_up = 1'b0;
      net_dn = 1'b0;
    end
    else if (cfg_r[`DCI_B_DIR_INV])
    begin
      // Both sides are read before either is written, so this swaps.
      {net_up, net_dn} = {net_dn, net_up};
    end
  end

  // One pending step at a time goes through the divider with the
  // carried remainder, so fractions are never lost.
  assign take_pos = (st_r == ST_IDLE) && pos_act && (pend_r != 16'h0) &&
                    (den != 16'h0);
  assign pos_t = pend_r[15] ? {rem_r[16], rem_r} - {2'h0, num} :
                 {rem_r[16], rem_r} + {2'h0, num};
  assign abs_t = pos_t[17] ? 18'h0 - pos_t : pos_t;

  // Pending count absorbs bursts faster than one step per division.
  always @*
  begin
    pend_nxt = pend_r;
    if (net_up)
    begin
      pend_nxt = pend_nxt + 16'h1;
    end
    if (net_dn)
    begin
      pend_nxt = pend_nxt - 16'h1;
    end
    if (take_pos)
    begin
      pend_nxt = pend_r[15] ? pend_nxt + 16'h1 : pend_nxt - 16'h1;
    end
    if (!pos_act)
    begin
      pend_nxt = 16'h0;
    end
  end

  // Divider request mux and owner state.
  always @*
  begin
    dvd = 48'h0;
    dvs = 16'h0;
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
      begin
        if (take_pwm)
        begin
          dvd = {16'h0000, abs_sc} * {32'h0, pwm_mag};
          dvs = per_cap_r;
          st_nxt = ST_PWM;
        end
        else if (take_pos)
        begin
          dvd = {30'h0, abs_t};
          dvs = den;
          st_nxt = ST_POS;
        end
      end
      ST_PWM: st_nxt = div_done ? ST_IDLE : ST_PWM;
      ST_POS: st_nxt = div_done ? ST_IDLE : ST_POS;
      default: st_nxt = ST_IDLE;
    endcase
  end

  dci_div u_div (
    .clk_in(clk_in),
    .rst_b_in(rst_n_r),
    .ce_in(ce_in),
    .start_in(take_pwm || take_pos),
    .dividend_in(dvd),
    .divisor_in(dvs),
    .busy_out(),
    .done_out(div_done),
    .quotient_out(quo),
    .remainder_out(rmd)
  );

  // Command registers and edge history.
  always @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      st_r <= ST_IDLE;
      neg_r <= 1'b0;
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
      pend_r <= 16'h0;
      rem_r <= 17'h0;
      cmd_out <= 32'h0;
      cmd_valid_out <= 1'b0;
      pos_cmd_out <= 32'h0;
    end
    else if (ce_in)
    begin
      st_r <= st_nxt;
      a_d_r <= a_in;
      b_d_r <= b_in;
      pend_r <= pend_nxt;
      cmd_valid_out <= zero_pwm || ((st_r == ST_PWM) && div_done);
      if (take_pwm)
      begin
        neg_r <= pwm_neg ^ scale_r[31];
      end
      if (take_pos)
      begin
        neg_r <= pos_t[17];
      end
      if (!pwm_act || zero_pwm)
      begin
        cmd_out <= 32'h0;
      end
      else if ((st_r == ST_PWM) && div_done)
      begin
        cmd_out <= neg_r ? 32'h0 - quo[31:0] : quo[31:0];
      end
      if ((st_r == ST_POS) && div_done && pos_act)
      begin
        pos_cmd_out <= neg_r ? pos_cmd_out - {14'h0, quo[17:0]} :
                       pos_cmd_out + {14'h0, quo[17:0]};
        rem_r <= neg_r ? 17'h0 - {1'b0, rmd} : {1'b0, rmd};
      end
    end
  end
endmodule // dci_front_end

// ===== sim/dci_checker.sv
// Port-level assertions for the digital command input front end.
`include "dci_defs.vh"
module dci_checker #(
  parameter [15:0] PWM_TMO = 16'hffff
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire ce_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_idx_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  input wire reg_ack_out,
  input wire dig_src_in,
  input wire [1:0] op_mode_in,
  input wire pwm_in,
  input wire sign_in,
  input wire [3:0] src_a_in,
  input wire [3:0] src_b_in,
  input wire neg_lim_in,
  input wire pos_lim_in,
  input wire home_in,
  input wire drv_en_in,
  input wire [15:0] raw_pins_in,
  input wire [31:0] cmd_out,
  input wire cmd_valid_out,
  input wire [31:0] pos_cmd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // High when the index names none of the three objects.
  wire unmapped = reg_idx_in != `DCI_IDX_CFG && reg_idx_in != `DCI_IDX_SCALE &&
    reg_idx_in != `DCI_IDX_DIN;
  // A register request taken on this edge.
  sequence s_req;
    ce_in && (reg_wr_in || reg_rd_in);
  endsequence
  // A read of the status word.
  sequence s_rd_din;
    ce_in && reg_rd_in && reg_idx_in == `DCI_IDX_DIN;
  endsequence
  // Pins held long enough to pass the two-flop synchroniser.
  sequence s_pins_quiet;
    $stable({drv_en_in, home_in, pos_lim_in, neg_lim_in, raw_pins_in})[*4];
  endsequence
  a_ack_follows: assert property (s_req |=> reg_ack_out)
    else $error("no acknowledge after a register request");
  a_ack_only: assert property (reg_ack_out |-> $past(ce_in &&
    (reg_wr_in || reg_rd_in))) else $error("acknowledge without a request");
  a_unmapped_zero: assert property (ce_in && reg_rd_in && unmapped
    |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
  a_status_resv: assert property (s_rd_din
    |=> reg_rdata_out[15:4] == 12'h000) else $error("status gap not zero");
  a_status_func: assert property (s_pins_quiet ##0 s_rd_din
    |=> reg_rdata_out[3:0] == $past({drv_en_in, home_in, pos_lim_in,
    neg_lim_in})) else $error("status function bits wrong");
  a_status_raw: assert property (s_pins_quiet ##0 s_rd_din
    |=> reg_rdata_out[31:16] == $past(raw_pins_in))
    else $error("status raw pin bits wrong");
  a_cmd_zero_pos: assert property (op_mode_in == `DCI_MODE_POS &&
    $past(op_mode_in) == `DCI_MODE_POS |-> cmd_out == 32'h0)
    else $error("current or velocity command in position mode");
  a_pos_frozen: assert property (op_mode_in != `DCI_MODE_POS &&
    $past(op_mode_in) != `DCI_MODE_POS |-> $stable(pos_cmd_out))
    else $error("position moved outside position mode");
  a_cmd_held: assert property (!cmd_valid_out && dig_src_in &&
    $past(dig_src_in, 2) && op_mode_in == $past(op_mode_in, 2) &&
    op_mode_in inside {`DCI_MODE_CUR, `DCI_MODE_VEL} |-> $stable(cmd_out))
    else $error("command changed without a valid pulse");
endmodule // dci_checker

// ===== sim/dci_ctrl_model.sv
// Motion controller model driving the PWM, sign and pulse pins.
module dci_ctrl_model (
  // Clock used only to pace the pins.
  input wire clk_in,
  // Command pins.
  output logic pwm_out,
  output logic sign_out,
  output wire [3:0] src_a_out,
  output wire [3:0] src_b_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int high_n = 0; // PWM high cycles; zero period means a stuck level.
  int per_n = 0; // PWM period in cycles.
  logic lvl = 1'b0; // Stuck level used while the period is zero.
  logic a = 1'b0; // Pulse line A of the selected source.
  logic b = 1'b0; // Pulse line B of the selected source.
  int src = 0; // Selected source; idle sources rest low.
  int q = 0; // Quadrature phase.
  assign src_a_out = {3'h0, a} << src;
  assign src_b_out = {3'h0, b} << src;
  // PWM generator; every change lands on a falling edge.
  initial
  begin
    pwm_out = 1'b0;
    sign_out = 1'b0;
    forever
    begin
      if (per_n == 0)
      begin
        @(negedge clk_in);
        pwm_out = lvl;
      end
      else
      begin
        pwm_out = 1'b1;
        repeat (high_n) @(negedge clk_in);
        pwm_out = 1'b0;
        repeat (per_n - high_n) @(negedge clk_in);
      end
    end
  end
  // Sends n counts, at least 60 cycles apart so the divider keeps up.
  task automatic move(input int fmt, input int n, input bit fwd);
    repeat (n)
    begin
      @(negedge clk_in);
      if (fmt == 0)
      begin
        b = !fwd;
        repeat (30) @(negedge clk_in);
        a = 1'b1;
        repeat (30) @(negedge clk_in);
        a = 1'b0;
      end
      else if (fmt == 1)
      begin
        if (fwd) a = 1'b1;
        else b = 1'b1;
        repeat (30) @(negedge clk_in);
        a = 1'b0;
        b = 1'b0;
        repeat (29) @(negedge clk_in);
      end
      else
      begin
        q = fwd ? (q + 1) % 4 : (q + 3) % 4;
        a = (q == 1 || q == 2);
        b = (q == 2 || q == 3);
        repeat (59) @(negedge clk_in);
      end
    end
  endtask
endmodule // dci_ctrl_model

// ===== sim/digital_command_input_front_end_tb.sv
// Self-checking bench for the digital command input front end.
`include "dci_defs.vh"
module digital_command_input_front_end_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [15:0] TMO = 16'h00c8; // Short PWM timeout keeps runs brief.
  logic clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, dig_src_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic neg_lim_in = 1'b0, pos_lim_in = 1'b0;
  logic home_in = 1'b0, drv_en_in = 1'b0;
  logic [15:0] reg_idx_in = 16'h0, raw_pins_in = 16'h0;
  logic [31:0] reg_wdata_in = 32'h0, rd, exp_pos = 32'h0;
  logic [1:0] op_mode_in = 2'h0;
  wire [31:0] reg_rdata_out, cmd_out, pos_cmd_out;
  wire reg_ack_out, cmd_valid_out, pwm_in, sign_in;
  wire [3:0] src_a_in, src_b_in;
  int failures = 0, compares = 0;
  initial forever #5 clk_in = !clk_in;
  dci_front_end #(.PWM_TMO(TMO)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .ce_in(ce_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_idx_in(reg_idx_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .dig_src_in(dig_src_in), .op_mode_in(op_mode_in), .pwm_in(pwm_in),
    .sign_in(sign_in), .src_a_in(src_a_in), .src_b_in(src_b_in),
    .neg_lim_in(neg_lim_in), .pos_lim_in(pos_lim_in), .home_in(home_in),
    .drv_en_in(drv_en_in), .raw_pins_in(raw_pins_in), .cmd_out(cmd_out),
    .cmd_valid_out(cmd_valid_out), .pos_cmd_out(pos_cmd_out));
  dci_ctrl_model i_ctl (.clk_in(clk_in), .pwm_out(pwm_in), .sign_out(sign_in),
    .src_a_out(src_a_in), .src_b_out(src_b_in));
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe pulse; the answer is taken one edge after the strobe.
  task automatic reg_op(input logic wr, input logic [15:0] idx,
    input logic [31:0] wd, output logic [31:0] data);
    @(negedge clk_in);
    reg_wr_in = wr;
    reg_rd_in = !wr;
    reg_idx_in = idx;
    reg_wdata_in = wd;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    check({31'h0, reg_ack_out}, 32'h1);
    data = reg_rdata_out;
  endtask
  // Sets a mode, options and PWM shape, then judges the third result, or the second for a stuck level.
  task automatic pwm_case(input logic [1:0] md, input logic [15:0] cfg,
    input int hi, input int per, input logic sg, input logic [31:0] ex);
    int n, cnt;
    // Park the pin low so results of the old shape finish unseen.
    i_ctl.per_n = 0;
    i_ctl.lvl = 1'b0;
    repeat (80) @(negedge clk_in);
    op_mode_in = md;
    reg_op(1'b1, `DCI_IDX_CFG, {16'h0, cfg}, rd);
    i_ctl.high_n = hi;
    i_ctl.per_n = per;
    i_ctl.lvl = 1'b1;
    i_ctl.sign_out = sg;
    n = 0;
    // A stuck level gives one result at its edge and one at the timeout.
    cnt = (per == 0) ? 2 : 3;
    while (cnt > 0 && n < 2000)
    begin
      @(posedge clk_in);
      #1;
      n++;
      if (cmd_valid_out === 1'b1) cnt--;
    end
    check(cnt, 32'h0);
    check(cmd_out, ex);
  endtask
  // Reset values, masking of reserved bits, read-only and unmapped places.
  task automatic t_regs;
    reg_op(1'b0, `DCI_IDX_CFG, 32'h0, rd);
    check(rd, {16'h0, `DCI_CFG_RST});
    reg_op(1'b0, `DCI_IDX_SCALE, 32'h0, rd);
    check(rd, `DCI_SCALE_RST);
    reg_op(1'b1, `DCI_IDX_CFG, 32'hffffffff, rd);
    reg_op(1'b0, `DCI_IDX_CFG, 32'h0, rd);
    check(rd, 32'h0000f30f);
    reg_op(1'b1, `DCI_IDX_SCALE, 32'h12345678, rd);
    reg_op(1'b0, `DCI_IDX_SCALE, 32'h0, rd);
    check(rd, 32'h12345678);
    reg_op(1'b1, 16'h2322, 32'hffffffff, rd);
    reg_op(1'b0, 16'h2322, 32'h0, rd);
    check(rd, 32'h0);
    reg_op(1'b1, `DCI_IDX_DIN, 32'hffffffff, rd);
    reg_op(1'b0, `DCI_IDX_DIN, 32'h0, rd);
    check(rd, 32'h0);
    $display("test registers done");
  endtask
  // Status word with two opposite pin patterns.
  task automatic t_status;
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk_in);
      {drv_en_in, home_in, pos_lim_in, neg_lim_in} = k ? 4'ha : 4'h5;
      raw_pins_in = k ? 16'h5a3c : 16'ha5c3;
      repeat (6) @(negedge clk_in);
      reg_op(1'b0, `DCI_IDX_DIN, 32'h0, rd);
      check(rd, k ? 32'h5a3c000a : 32'ha5c30005);
    end
    $display("test status done");
  endtask
  // Sign/magnitude, offset, inversion and full duty cases.
  task automatic t_pwm;
    reg_op(1'b1, `DCI_IDX_SCALE, 32'h000003e8, rd);
    pwm_case(`DCI_MODE_CUR, 16'h0001, 25, 100, 1'b0, 32'h000000fa);
    pwm_case(`DCI_MODE_CUR, 16'h0001, 25, 100, 1'b1, 32'hffffff06);
    pwm_case(`DCI_MODE_CUR, 16'h0005, 25, 100, 1'b1, 32'h000000fa);
    pwm_case(`DCI_MODE_VEL, 16'h0000, 75, 100, 1'b0, 32'h000001f4);
    pwm_case(`DCI_MODE_VEL, 16'h0000, 25, 100, 1'b0, 32'hfffffe0c);
    pwm_case(`DCI_MODE_VEL, 16'h0002, 25, 100, 1'b0, 32'h000001f4);
    pwm_case(`DCI_MODE_CUR, 16'h0001, 0, 0, 1'b0, 32'h0);
    pwm_case(`DCI_MODE_CUR, 16'h0009, 0, 0, 1'b0, 32'h000003e8);
    @(negedge clk_in);
    dig_src_in = 1'b0;
    repeat (20) @(negedge clk_in);
    check(cmd_out, 32'h0);
    dig_src_in = 1'b1;
    $display("test pwm done");
  endtask
  // Ratio, every format and source, direction and edge options.
  task automatic t_pos;
    @(negedge clk_in);
    op_mode_in = `DCI_MODE_POS;
    reg_op(1'b1, `DCI_IDX_CFG, 32'h0, rd);
    reg_op(1'b1, `DCI_IDX_SCALE, 32'h00030001, rd);
    i_ctl.move(0, 6, 1'b1);
    repeat (80) @(negedge clk_in);
    exp_pos = exp_pos + 32'h2;
    check(pos_cmd_out, exp_pos);
    reg_op(1'b1, `DCI_IDX_SCALE, 32'h00010001, rd);
    for (int s = 0; s < 4; s++)
      for (int f = 0; f < 3; f++)
      begin
        reg_op(1'b1, `DCI_IDX_CFG, (s << 14) | (f << 8), rd);
        i_ctl.src = s;
        i_ctl.move(f, 4, 1'b1);
        repeat (80) @(negedge clk_in);
        exp_pos = exp_pos + 32'h4;
        check(pos_cmd_out, exp_pos);
      end
    i_ctl.src = 0;
    reg_op(1'b1, `DCI_IDX_CFG, 32'h00002000, rd);
    i_ctl.move(0, 4, 1'b1);
    repeat (80) @(negedge clk_in);
    exp_pos = exp_pos - 32'h4;
    check(pos_cmd_out, exp_pos);
    reg_op(1'b1, `DCI_IDX_CFG, 32'h00001000, rd);
    @(negedge clk_in);
    i_ctl.a = 1'b1;
    repeat (80) @(negedge clk_in);
    check(pos_cmd_out, exp_pos);
    i_ctl.a = 1'b0;
    repeat (80) @(negedge clk_in);
    check(pos_cmd_out, exp_pos + 32'h1);
    op_mode_in = 2'h0;
    $display("test position done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence after ten cycles of reset.
  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_regs;
    t_status;
    t_pwm;
    t_pos;
    wrap_up;
  end
  // Watchdog well beyond the expected run of about 7600 cycles.
  initial
  begin
    #400000;
    failures++;
    wrap_up;
  end
endmodule // digital_command_input_front_end_tb
bind dci_front_end dci_checker #(.PWM_TMO(PWM_TMO)) i_chk (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_idx_in(reg_idx_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
  .dig_src_in(dig_src_in), .op_mode_in(op_mode_in), .pwm_in(pwm_in),
  .sign_in(sign_in), .src_a_in(src_a_in), .src_b_in(src_b_in),
  .neg_lim_in(neg_lim_in), .pos_lim_in(pos_lim_in), .home_in(home_in),
  .drv_en_in(drv_en_in), .raw_pins_in(raw_pins_in), .cmd_out(cmd_out),
  .cmd_valid_out(cmd_valid_out), .pos_cmd_out(pos_cmd_out));
